// ==== rsbp_pipe_model.sv ====
// Behavioural resolve side of the execution pipeline for the predictor bench
`timescale 1ns/1ps
module rsbp_pipe_model (
    input  wire logic                    clk,
    input  wire logic                    go,
    input  wire rsbp_pkg::rsbp_resolve_t req,
    input  wire logic [7:0]              dly,
    output rsbp_pkg::rsbp_resolve_t      res
);
    logic [7:0] cnt_q;
    logic       busy_q;
    initial begin
        res = '0;
        cnt_q = 8'h00;
        busy_q = 1'b0;
    end
    // Idle fields toggle so a stale resolve value is never mistaken for a live one
    always @(negedge clk) begin
        res <= ~res;
        res.valid <= 1'b0;
        if (go) begin
            busy_q <= 1'b1;
            cnt_q <= dly;
        end else if (busy_q && cnt_q == 8'h00) begin
            res <= req;
            res.valid <= 1'b1;
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule

// ==== rsbp_pkg.sv ====
// Shared types and constants of the return-stack branch predictor
package rsbp_pkg;

    localparam int unsigned ADDR_W      = 32;
    localparam int unsigned RAS_DEPTH   = 16;
    localparam int unsigned RAS_PTR_W   = 4;
    localparam int unsigned RAS_CNT_W   = 5;
    localparam int unsigned TBL_IDX_W   = 4;
    localparam int unsigned TBL_IDX_LSB = 2;
    localparam int unsigned TBL_TAG_W   = 10;
    localparam int unsigned TBL_TAG_LSB = 6;
    localparam int unsigned TBL_ENTRIES = 16;

    // Misprediction penalty and segment-base surcharge, in clk cycles
    localparam logic [7:0] MIS_BASE_CYC = 8'h14;
    localparam logic [7:0] CS_EXTRA_CYC = 8'h02;
    localparam logic [7:0] PEN_LAST     = 8'h01;

    // Execution latencies reported per fetched op
    localparam logic [3:0] LOOP_LAT_32 = 4'h7;
    localparam logic [3:0] LOOP_LAT_64 = 4'h8;
    localparam logic [3:0] DEC_LAT     = 4'h1;
    localparam logic [3:0] JNZ_LAT     = 4'h1;

    // Saturating direction counter
    localparam logic [1:0] CTR_ALLOC = 2'h2;
    localparam logic [1:0] CTR_MAX   = 2'h3;
    localparam logic [1:0] CTR_MIN   = 2'h0;

    localparam logic [ADDR_W-1:0] CS_BASE_ZERO = 32'h0000_0000;

    typedef enum logic [3:0] {
        RSBP_OP_NONE                 = 4'b0000,
        RSBP_OP_NEAR_CALL            = 4'b0001,
        RSBP_OP_NEAR_RET             = 4'b0010,
        RSBP_OP_COND                 = 4'b0011,
        RSBP_OP_JMP                  = 4'b0100,
        RSBP_OP_LOOP                 = 4'b0101,
        RSBP_OP_DEC_REG              = 4'b0110,
        RSBP_OP_JNZ                  = 4'b0111,
        RSBP_OP_FAR_JMP              = 4'b1000,
        RSBP_OP_FAR_CALL             = 4'b1001,
        RSBP_OP_FAR_RET              = 4'b1010,
        RSBP_OP_SOFT_INT             = 4'b1011,
        RSBP_OP_OVF_INT              = 4'b1100,
        RSBP_OP_INTERRUPT_RETURN_OP  = 4'b1101
    } rsbp_op_t;

    typedef enum logic [1:0] {
        RSBP_ST_RUN     = 2'b00,
        RSBP_ST_BUBBLE  = 2'b01,
        RSBP_ST_WAIT    = 2'b10,
        RSBP_ST_PENALTY = 2'b11
    } rsbp_state_t;

    typedef struct packed {
        logic              valid;
        rsbp_op_t          op;
        logic [ADDR_W-1:0] pc;
        logic [3:0]        len;
        logic              disp_zero;
        logic [ADDR_W-1:0] target;
    } rsbp_fetch_t;

    typedef struct packed {
        logic              valid;
        rsbp_op_t          op;
        logic [ADDR_W-1:0] pc;
        logic              taken;
        logic [ADDR_W-1:0] target;
        logic              pred_taken;
        logic [ADDR_W-1:0] pred_target;
    } rsbp_resolve_t;

    typedef struct packed {
        logic              valid;
        logic              taken;
        logic [ADDR_W-1:0] target;
    } rsbp_pred_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] target;
    } rsbp_redirect_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] cycles;
    } rsbp_lat_t;

endpackage

// ==== rsbp_ras.sv ====
// Circular return-address stack that drops its oldest entry on overflow
`timescale 1ns/1ps
module rsbp_ras (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         push,
    input  wire logic                         pop,
    input  wire logic [rsbp_pkg::ADDR_W-1:0]  push_addr,
    output logic      [rsbp_pkg::ADDR_W-1:0]  top_addr,
    output logic                              top_valid,
    output logic      [rsbp_pkg::RAS_CNT_W-1:0] count,
    output logic                              full
);

    logic [rsbp_pkg::ADDR_W-1:0]    mem_q [rsbp_pkg::RAS_DEPTH];
    logic [rsbp_pkg::RAS_PTR_W-1:0] wr_ptr_q;
    logic [rsbp_pkg::RAS_CNT_W-1:0] cnt_q;
    logic [rsbp_pkg::RAS_PTR_W-1:0] top_ptr;

    assign top_ptr   = wr_ptr_q - 4'h1;
    assign top_addr  = mem_q[top_ptr];
    assign top_valid = (cnt_q != 5'h00);
    assign full      = (cnt_q == 5'(rsbp_pkg::RAS_DEPTH));
    assign count     = cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // Storage: wrapping pointer overwrites the oldest slot when full
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= push_addr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_q <= 4'h0;
            cnt_q    <= 5'h00;
        end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 4'h1;
            if (!full) begin
                cnt_q <= cnt_q + 5'h01;
            end
        end else if (pop && top_valid) begin
            wr_ptr_q <= top_ptr;
            cnt_q    <= cnt_q - 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_ras_overflow;
        @(posedge clk) disable iff (rst)
        (push && full) |=> (full && top_addr == $past(push_addr));
    endproperty
    a_ras_overflow: assert property (p_ras_overflow)
        else $error("overflow lost newest entry");

    property p_ras_empty_pop;
        @(posedge clk) disable iff (rst)
        (pop && !push && !top_valid) |=> (count == 5'h00);
    endproperty
    a_ras_empty_pop: assert property (p_ras_empty_pop)
        else $error("pop of empty stack changed count");

endmodule

// ==== rsbp_top.sv ====
// Front-end branch predictor with return stack, direction table and penalty timing
//
// Operation
// - A fetched near call pushes the address after the call onto the stack.
// - A fetched return with a nonempty stack predicts the stack top as target and pops it.
// - Pushing onto a full stack drops the oldest entry, keeps newer ones.
// - A zero-displacement call leaves the return stack untouched.
// - In 32-bit mode a nonzero code base adds two penalty cycles.
// - In 64-bit mode the code base is treated as zero.
// - The counted-loop op reports 7 cycles in 32-bit, 8 in 64-bit.
// - Register decrement and jump-if-not-zero each report 1 cycle latency.
// - Far jumps, calls, returns and interrupt ops get no prediction.
// - A predicted-taken branch costs one fetch bubble; not-taken costs none.
// - Taken conditional branches allocate table entries; not-taken ones never allocate.
// - A return resolved with a wrong target is handled as a mispredict.
`timescale 1ns/1ps
module rsbp_top (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          long_mode,
    input  wire logic [rsbp_pkg::ADDR_W-1:0]   cs_base,
    input  wire rsbp_pkg::rsbp_fetch_t         fetch_i,
    input  wire rsbp_pkg::rsbp_resolve_t       res_i,
    output rsbp_pkg::rsbp_pred_t               pred_q,
    output logic                               fetch_ready_q,
    output rsbp_pkg::rsbp_redirect_t           redir_q,
    output rsbp_pkg::rsbp_lat_t                lat_q
);

    rsbp_pkg::rsbp_state_t           state_q;
    rsbp_pkg::rsbp_state_t           state_d;
    logic [7:0]                      pen_cnt_q;
    logic [rsbp_pkg::ADDR_W-1:0]     redir_tgt_q;

    logic                            fire;
    logic                            mis;
    logic                            far_op;
    logic                            cond_op;
    logic                            res_cond;
    logic [7:0]                      penalty;
    logic [rsbp_pkg::ADDR_W-1:0]     next_pc;

    logic                            ras_push;
    logic                            ras_pop;
    logic [rsbp_pkg::ADDR_W-1:0]     ras_top;
    logic                            ras_top_valid;
    logic [rsbp_pkg::RAS_CNT_W-1:0]  ras_count;
    logic                            ras_full;

    logic                            tbl_vld_q [rsbp_pkg::TBL_ENTRIES];
    logic [rsbp_pkg::TBL_TAG_W-1:0]  tbl_tag_q [rsbp_pkg::TBL_ENTRIES];
    logic [rsbp_pkg::ADDR_W-1:0]     tbl_tgt_q [rsbp_pkg::TBL_ENTRIES];
    logic [1:0]                      tbl_ctr_q [rsbp_pkg::TBL_ENTRIES];

    logic [rsbp_pkg::TBL_IDX_W-1:0]  f_idx;
    logic [rsbp_pkg::TBL_TAG_W-1:0]  f_tag;
    logic [rsbp_pkg::TBL_IDX_W-1:0]  r_idx;
    logic [rsbp_pkg::TBL_TAG_W-1:0]  r_tag;
    logic                            f_hit;
    logic                            r_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the fetched op and of the resolution
    assign far_op = (fetch_i.op == rsbp_pkg::RSBP_OP_FAR_JMP)
                 || (fetch_i.op == rsbp_pkg::RSBP_OP_FAR_CALL)
                 || (fetch_i.op == rsbp_pkg::RSBP_OP_FAR_RET)
                 || (fetch_i.op == rsbp_pkg::RSBP_OP_SOFT_INT)
                 || (fetch_i.op == rsbp_pkg::RSBP_OP_OVF_INT)
                 || (fetch_i.op == rsbp_pkg::RSBP_OP_INTERRUPT_RETURN_OP);
    assign cond_op = (fetch_i.op == rsbp_pkg::RSBP_OP_COND)
                  || (fetch_i.op == rsbp_pkg::RSBP_OP_JNZ);
    assign res_cond = res_i.valid && ((res_i.op == rsbp_pkg::RSBP_OP_COND)
                   || (res_i.op == rsbp_pkg::RSBP_OP_JNZ));

    // Wrong direction or wrong target, returns included
    assign mis = res_i.valid
              && (state_q == rsbp_pkg::RSBP_ST_RUN || state_q == rsbp_pkg::RSBP_ST_BUBBLE)
              && ((res_i.taken != res_i.pred_taken)
                  || (res_i.taken && res_i.target != res_i.pred_target));

    // A mispredict flushes the op being fetched in the same cycle
    assign fire = fetch_i.valid && fetch_ready_q && !mis
               && (state_q == rsbp_pkg::RSBP_ST_RUN);

    assign next_pc = fetch_i.pc + {28'h000_0000, fetch_i.len};

    // Segment base only costs time outside 64-bit mode
    assign penalty = (!long_mode && cs_base != rsbp_pkg::CS_BASE_ZERO)
                   ? rsbp_pkg::MIS_BASE_CYC + rsbp_pkg::CS_EXTRA_CYC
                   : rsbp_pkg::MIS_BASE_CYC;

    assign ras_push = fire && (fetch_i.op == rsbp_pkg::RSBP_OP_NEAR_CALL)
                   && !fetch_i.disp_zero;
    assign ras_pop  = fire && (fetch_i.op == rsbp_pkg::RSBP_OP_NEAR_RET);

    rsbp_ras u_ras (
        .clk       (clk),
        .rst       (rst),
        .push      (ras_push),
        .pop       (ras_pop),
        .push_addr (next_pc),
        .top_addr  (ras_top),
        .top_valid (ras_top_valid),
        .count     (ras_count),
        .full      (ras_full)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Direction table lookup
    assign f_idx = fetch_i.pc[rsbp_pkg::TBL_IDX_LSB +: rsbp_pkg::TBL_IDX_W];
    assign f_tag = fetch_i.pc[rsbp_pkg::TBL_TAG_LSB +: rsbp_pkg::TBL_TAG_W];
    assign r_idx = res_i.pc[rsbp_pkg::TBL_IDX_LSB +: rsbp_pkg::TBL_IDX_W];
    assign r_tag = res_i.pc[rsbp_pkg::TBL_TAG_LSB +: rsbp_pkg::TBL_TAG_W];
    assign f_hit = tbl_vld_q[f_idx] && (tbl_tag_q[f_idx] == f_tag);
    assign r_hit = tbl_vld_q[r_idx] && (tbl_tag_q[r_idx] == r_tag);

    // Only taken outcomes claim an entry; not-taken weakens a hit, and frees it when its counter is already at the minimum
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < rsbp_pkg::TBL_ENTRIES; i++) begin
                tbl_vld_q[i] <= 1'b0;
                tbl_ctr_q[i] <= rsbp_pkg::CTR_MIN;
            end
        end else if (res_cond && res_i.taken) begin
            tbl_vld_q[r_idx] <= 1'b1;
            if (!r_hit) begin
                tbl_ctr_q[r_idx] <= rsbp_pkg::CTR_ALLOC;
            end else if (tbl_ctr_q[r_idx] != rsbp_pkg::CTR_MAX) begin
                tbl_ctr_q[r_idx] <= tbl_ctr_q[r_idx] + 2'h1;
            end
        end else if (res_cond && r_hit) begin
            if (tbl_ctr_q[r_idx] == rsbp_pkg::CTR_MIN) begin
                tbl_vld_q[r_idx] <= 1'b0;
            end else begin
                tbl_ctr_q[r_idx] <= tbl_ctr_q[r_idx] - 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (res_cond && res_i.taken) begin
            tbl_tag_q[r_idx] <= r_tag;
            tbl_tgt_q[r_idx] <= res_i.target;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fetch sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            rsbp_pkg::RSBP_ST_RUN, rsbp_pkg::RSBP_ST_BUBBLE: begin
                if (mis) begin
                    state_d = rsbp_pkg::RSBP_ST_PENALTY;
                end else if (state_q == rsbp_pkg::RSBP_ST_BUBBLE) begin
                    state_d = rsbp_pkg::RSBP_ST_RUN;
                end else if (fire) begin
                    case (fetch_i.op)
                        rsbp_pkg::RSBP_OP_NEAR_CALL, rsbp_pkg::RSBP_OP_JMP: begin
                            state_d = rsbp_pkg::RSBP_ST_BUBBLE;
                        end
                        rsbp_pkg::RSBP_OP_NEAR_RET: begin
                            state_d = ras_top_valid ? rsbp_pkg::RSBP_ST_BUBBLE
                                                    : rsbp_pkg::RSBP_ST_WAIT;
                        end
                        rsbp_pkg::RSBP_OP_COND, rsbp_pkg::RSBP_OP_JNZ: begin
                            if (f_hit && tbl_ctr_q[f_idx][1]) begin
                                state_d = rsbp_pkg::RSBP_ST_BUBBLE;
                            end
                        end
                        default: begin
                            if (far_op) begin
                                state_d = rsbp_pkg::RSBP_ST_WAIT;
                            end
                        end
                    endcase
                end
            end
            rsbp_pkg::RSBP_ST_WAIT: begin
                if (res_i.valid) begin
                    state_d = rsbp_pkg::RSBP_ST_RUN;
                end
            end
            rsbp_pkg::RSBP_ST_PENALTY: begin
                if (pen_cnt_q == rsbp_pkg::PEN_LAST) begin
                    state_d = rsbp_pkg::RSBP_ST_RUN;
                end
            end
            default: begin
                state_d = rsbp_pkg::RSBP_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q       <= rsbp_pkg::RSBP_ST_RUN;
            fetch_ready_q <= 1'b0;
        end else begin
            state_q       <= state_d;
            fetch_ready_q <= (state_d == rsbp_pkg::RSBP_ST_RUN);
        end
    end

    // Penalty countdown; the redirect leaves at its end
    always_ff @(posedge clk) begin
        if (rst) begin
            pen_cnt_q   <= 8'h00;
            redir_tgt_q <= 32'h0000_0000;
        end else if (mis) begin
            pen_cnt_q   <= penalty;
            redir_tgt_q <= res_i.taken ? res_i.target : res_i.pc + 32'h0000_0001;
        end else if (state_q == rsbp_pkg::RSBP_ST_PENALTY) begin
            pen_cnt_q <= pen_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            redir_q <= '0;
        end else if (state_q == rsbp_pkg::RSBP_ST_PENALTY && pen_cnt_q == rsbp_pkg::PEN_LAST) begin
            redir_q.valid  <= 1'b1;
            redir_q.target <= redir_tgt_q;
        end else if (state_q == rsbp_pkg::RSBP_ST_WAIT && res_i.valid) begin
            redir_q.valid  <= 1'b1;
            redir_q.target <= res_i.target;
        end else begin
            redir_q.valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prediction and latency reports
    always_ff @(posedge clk) begin
        if (rst) begin
            pred_q <= '0;
        end else begin
            pred_q <= '0;
            if (fire) begin
                case (fetch_i.op)
                    rsbp_pkg::RSBP_OP_NEAR_CALL, rsbp_pkg::RSBP_OP_JMP: begin
                        pred_q.valid  <= 1'b1;
                        pred_q.taken  <= 1'b1;
                        pred_q.target <= fetch_i.target;
                    end
                    rsbp_pkg::RSBP_OP_NEAR_RET: begin
                        pred_q.valid  <= ras_top_valid;
                        pred_q.taken  <= ras_top_valid;
                        // No stale stack slot leaks out when nothing is predicted
                        pred_q.target <= ras_top_valid ? ras_top : '0;
                    end
                    rsbp_pkg::RSBP_OP_COND, rsbp_pkg::RSBP_OP_JNZ: begin
                        pred_q.valid  <= 1'b1;
                        pred_q.taken  <= f_hit && tbl_ctr_q[f_idx][1];
                        pred_q.target <= f_hit ? tbl_tgt_q[f_idx] : next_pc;
                    end
                    default: begin
                        pred_q.valid <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lat_q <= '0;
        end else begin
            lat_q <= '0;
            if (fire) begin
                case (fetch_i.op)
                    rsbp_pkg::RSBP_OP_LOOP: begin
                        lat_q.valid  <= 1'b1;
                        lat_q.cycles <= long_mode ? rsbp_pkg::LOOP_LAT_64
                                                  : rsbp_pkg::LOOP_LAT_32;
                    end
                    rsbp_pkg::RSBP_OP_DEC_REG: begin
                        lat_q.valid  <= 1'b1;
                        lat_q.cycles <= rsbp_pkg::DEC_LAT;
                    end
                    rsbp_pkg::RSBP_OP_JNZ: begin
                        lat_q.valid  <= 1'b1;
                        lat_q.cycles <= rsbp_pkg::JNZ_LAT;
                    end
                    default: begin
                        lat_q.valid <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_call_push;
        @(posedge clk) disable iff (rst)
        ras_push |=> (ras_top_valid && ras_top == $past(next_pc));
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("call did not push return address");

    property p_ret_pred;
        @(posedge clk) disable iff (rst)
        (ras_pop && ras_top_valid) |=> (pred_q.taken && pred_q.target == $past(ras_top));
    endproperty
    a_ret_pred: assert property (p_ret_pred)
        else $error("return not predicted from stack top");

    property p_zero_call;
        @(posedge clk) disable iff (rst)
        (fire && fetch_i.op == rsbp_pkg::RSBP_OP_NEAR_CALL && fetch_i.disp_zero)
            |=> (ras_count == $past(ras_count));
    endproperty
    a_zero_call: assert property (p_zero_call)
        else $error("zero displacement call changed stack");

    property p_cs_pen;
        @(posedge clk) disable iff (rst)
        (mis && !long_mode && cs_base != rsbp_pkg::CS_BASE_ZERO)
            |=> (pen_cnt_q == rsbp_pkg::MIS_BASE_CYC + rsbp_pkg::CS_EXTRA_CYC);
    endproperty
    a_cs_pen: assert property (p_cs_pen)
        else $error("segment base surcharge missing");

    property p_long_pen;
        @(posedge clk) disable iff (rst)
        (mis && long_mode) |=> (pen_cnt_q == rsbp_pkg::MIS_BASE_CYC);
    endproperty
    a_long_pen: assert property (p_long_pen)
        else $error("segment base charged in 64-bit mode");

    property p_loop_lat;
        @(posedge clk) disable iff (rst)
        (fire && fetch_i.op == rsbp_pkg::RSBP_OP_LOOP)
            |=> (lat_q.valid && lat_q.cycles == ($past(long_mode) ? 4'h8 : 4'h7));
    endproperty
    a_loop_lat: assert property (p_loop_lat)
        else $error("loop latency wrong");

    property p_dec_lat;
        @(posedge clk) disable iff (rst)
        (fire && (fetch_i.op == rsbp_pkg::RSBP_OP_DEC_REG || fetch_i.op == rsbp_pkg::RSBP_OP_JNZ))
            |=> (lat_q.valid && lat_q.cycles == 4'h1);
    endproperty
    a_dec_lat: assert property (p_dec_lat)
        else $error("decrement or jnz latency wrong");

    property p_far;
        @(posedge clk) disable iff (rst)
        (fire && far_op) |=> (!pred_q.valid && state_q == rsbp_pkg::RSBP_ST_WAIT);
    endproperty
    a_far: assert property (p_far)
        else $error("far transfer was predicted");

    property p_bubble;
        @(posedge clk) disable iff (rst)
        (pred_q.valid && pred_q.taken) |-> !fetch_ready_q ##1 (fetch_ready_q || mis || $past(mis));
    endproperty
    a_bubble: assert property (p_bubble)
        else $error("taken prediction bubble wrong");

    property p_no_alloc;
        @(posedge clk) disable iff (rst)
        (res_cond && !res_i.taken && !r_hit) |=> (tbl_vld_q[$past(r_idx)] == $past(tbl_vld_q[r_idx]));
    endproperty
    a_no_alloc: assert property (p_no_alloc)
        else $error("not-taken branch allocated entry");

    property p_ret_mis;
        @(posedge clk) disable iff (rst)
        (mis && res_i.op == rsbp_pkg::RSBP_OP_NEAR_RET)
            |=> (state_q == rsbp_pkg::RSBP_ST_PENALTY) [*2];
    endproperty
    a_ret_mis: assert property (p_ret_mis)
        else $error("wrong return target not penalised");

    property p_empty_ret;
        @(posedge clk) disable iff (rst)
        (ras_pop && !ras_top_valid) |=> (!pred_q.valid && !fetch_ready_q
                                         && state_q == rsbp_pkg::RSBP_ST_WAIT);
    endproperty
    a_empty_ret: assert property (p_empty_ret)
        else $error("empty stack return did not stall");

endmodule

// ==== tb.sv ====
// Self-checking bench of the return-stack branch predictor
`timescale 1ns/1ps
module tb;
    logic                     clk, rst, long_mode, go, rdy;
    logic [31:0]              cs_base;
    logic [7:0]               dly;
    rsbp_pkg::rsbp_fetch_t    f;
    rsbp_pkg::rsbp_resolve_t  rq, rs;
    rsbp_pkg::rsbp_pred_t     pred;
    rsbp_pkg::rsbp_redirect_t redir;
    rsbp_pkg::rsbp_lat_t      lat;
    int                       err_total, n_checks, n;
    rsbp_top DUT (.clk(clk), .rst(rst), .long_mode(long_mode), .cs_base(cs_base),
        .fetch_i(f), .res_i(rs), .pred_q(pred), .fetch_ready_q(rdy), .redir_q(redir),
        .lat_q(lat));
    rsbp_pipe_model PIPE (.clk(clk), .go(go), .req(rq), .dly(dly), .res(rs));
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wait_for(input logic sel);
        n = 0;
        while ((sel ? rs.valid : rdy) !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 300) begin
                err_total++;
                report_and_stop();
            end
        end
    endtask
    // Expected value packs {ready, latency, prediction} seen one cycle after taking
    task automatic fetch(input logic [3:0] op, input logic [31:0] pc, input logic dz,
                         input logic [39:0] e);
        // One idle edge between fetches so valid is never driven twice in a step
        @(negedge clk);
        wait_for(1'b0);
        f <= '{1'b1, rsbp_pkg::rsbp_op_t'(op), pc, 4'h5, dz, 32'h0000_0400};
        @(negedge clk);
        f.valid <= 1'b0;
        chk("fetch", e, {rdy, lat, pred});
    endtask
    // Echoed direction equals the outcome: only a taken target other than 105 mispredicts
    task automatic resolve(input logic [3:0] op, input logic [31:0] pc, input logic tk,
                           input logic [31:0] tg, input logic [7:0] d);
        rq <= '{1'b0, rsbp_pkg::rsbp_op_t'(op), pc, tk, tg, tk, 32'h105};
        dly <= d;
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        wait_for(1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic sc_stack();
        for (int i = 0; i < 17; i++) fetch(4'h1, 32'(i * 16), 1'b0, {8'h03, 32'h400});
        for (int i = 16; i > 0; i--) fetch(4'h2, 32'h900, 1'b0, {8'h03, 32'(i * 16 + 5)});
        fetch(4'h1, 32'h100, 1'b1, {8'h03, 32'h400});
        fetch(4'h2, 32'h900, 1'b0, 40'h0);
        resolve(4'h2, 32'h900, 1'b1, 32'h777, 8'h05);
        chk("redir", {7'h01, 1'b1, 32'h777}, {rdy, redir});
    endtask
    task automatic sc_far();
        for (int k = 0; k < 6; k++) begin
            fetch(4'h8 + 4'(k), 32'h500, 1'b0, 40'h0);
            resolve(4'h8 + 4'(k), 32'h900, 1'b1, 32'(32'h5a0 + k), 8'(k * 3));
            chk("far_redir", {7'h01, 1'b1, 32'(32'h5a0 + k)}, {rdy, redir});
        end
    endtask
    // Not-taken outcome must not claim an entry; a taken one must
    task automatic sc_table();
        resolve(4'h3, 32'h940, 1'b0, 32'h105, 8'h01);
        fetch(4'h3, 32'h940, 1'b0, {8'h82, 32'h945});
        resolve(4'h3, 32'h940, 1'b1, 32'h105, 8'h01);
        fetch(4'h3, 32'h940, 1'b0, {8'h03, 32'h105});
        fetch(4'h4, 32'h980, 1'b0, {8'h03, 32'h400});
    endtask
    task automatic sc_latency();
        fetch(4'h5, 32'h2000, 1'b0, {6'h37, 34'h0});
        long_mode <= 1'b1;
        fetch(4'h5, 32'h2000, 1'b0, {6'h38, 34'h0});
        fetch(4'h6, 32'h2010, 1'b0, {6'h31, 34'h0});
        fetch(4'h7, 32'h3000, 1'b0, {6'h31, 2'b10, 32'h3005});
    endtask
    // Penalty grows by two only for a nonzero base outside 64-bit mode
    task automatic sc_penalty();
        for (int m = 0; m < 3; m++) begin
            long_mode <= (m == 2);
            cs_base <= (m > 0) ? 32'h0000_1000 : 32'h0;
            @(negedge clk);
            resolve(4'h2, 32'h900, 1'b1, 32'h888, 8'h02);
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (redir.valid !== 1'b1 && n < 40);
            chk("penalty", 40'(rsbp_pkg::MIS_BASE_CYC) + ((m == 1) ? 40'(rsbp_pkg::CS_EXTRA_CYC)
                : 40'h0), 40'(n));
            chk("mis_redir", {7'h01, 1'b1, 32'h888}, {rdy, redir});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rst, long_mode, go, cs_base, dly, f, rq} = '0;
        err_total = 0;
        n_checks = 0;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        sc_stack();
        sc_far();
        sc_latency();
        sc_table();
        sc_penalty();
        report_and_stop();
    end
endmodule
